// ===== ccbd_pkg.sv
// Shared constants, field positions and state type of the codec control byte decoder.
// Assumes every user runs on the single 20 MHz mclk domain.
//
// Contract
// - Control byte bits 3:2 give 11 idle, 01 status, x0 coefficient operation.
// - An idle byte changes no configuration and moves no data bytes.
// - Status byte: address bit7, read flag bit6, power 5, conference 4, length 1:0.
// - Status power bit 1 selects operating state, 0 selects standby.
// - Conference bit set asks for summing channel A and B voice bytes.
// - Write length 00 none, 11 one byte filter, 10 pin then filter.
// - Filter bit7 set disables balance; bits 6:3 clear disable their filters.
// - Test field bits 2:0 select loopbacks, high pass off, receive cut.
// - Pin bits 7:4 make signaling pins D to A inputs when 1.
// - Expansion flag tells whether external signaling expansion logic exists.
// - Addressing bit 0 means shared port and forces pin A to input.
// - Companding bit 1 selects mu-law, 0 selects A-law.
// - Coefficient source bit 0 uses RAM balance coefficients, 1 fixed ones.
// - Reset clears the filter register and sets the pin register to ones.
// - Status read returns pin register then filter register; the code answers only a read with length 10.
// - Coefficient write codes select RAM areas; bit7 picks second codec.
// - Coefficient read codes are the write codes with bit6 set.
// - Coefficient readback ends with pin register then filter register.
// - Three dedicated flag inputs, three flag outputs, four configurable pins.
// - Signaling byte: flags 7:5, pins D to A 4:1, expansion bit 0.
// - Unused transmit bits low, or released with expansion; shared halves split.
package ccbd_pkg;
	localparam int OP_HI = 3;
	localparam int OP_LO = 2;
	localparam int ADDR_BIT = 7;
	localparam int RD_BIT = 6;
	localparam int PWR_BIT = 5;
	localparam int CONF_BIT = 4;
	localparam int LEN_HI = 1;
	localparam int CODE_HI = 5;
	localparam logic [1:0] LEN_ONE = 2'h3;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [7:0] FILT_RESET = 8'h00;
	localparam logic [7:0] PIN_RESET = 8'hff;
	localparam int BAL_OFF_BIT = 7;
	localparam int IMP_ON_BIT = 6;
	localparam int TXF_ON_BIT = 5;
	localparam int RXF_ON_BIT = 4;
	localparam int GAIN_ON_BIT = 3;
	localparam int TEST_HI = 2;
	localparam logic [2:0] TEST_ALOOP = 3'h1;
	localparam logic [2:0] TEST_HPOFF = 3'h2;
	localparam logic [2:0] TEST_RXCUT = 3'h3;
	localparam logic [2:0] TEST_DLBAL = 3'h6;
	localparam logic [2:0] TEST_DLPCM = 3'h7;
	localparam int DIR_HI = 7;
	localparam int DIR_LO = 4;
	localparam int EXP_BIT = 3;
	localparam int AM_BIT = 2;
	localparam int LAW_BIT = 1;
	localparam int FIXB_BIT = 0;
	localparam logic [5:0] C_BAL1 = 6'h03;
	localparam logic [5:0] C_BAL2 = 6'h0b;
	localparam logic [5:0] C_BDLY = 6'h18;
	localparam logic [5:0] C_IMP = 6'h13;
	localparam logic [5:0] C_TXF = 6'h23;
	localparam logic [5:0] C_RXF = 6'h2b;
	localparam logic [5:0] C_GAIN = 6'h30;
	localparam logic [3:0] LEN_LONG = 4'h8;
	localparam logic [3:0] LEN_SHORT = 4'h4;
	localparam logic [3:0] LEN_NONE = 4'h0;
	localparam logic [3:0] CNT_LAST = 4'h1;
	localparam logic [5:0] B_BAL1 = 6'h00;
	localparam logic [5:0] B_BAL2 = 6'h08;
	localparam logic [5:0] B_BDLY = 6'h10;
	localparam logic [5:0] B_IMP = 6'h14;
	localparam logic [5:0] B_TXF = 6'h1c;
	localparam logic [5:0] B_RXF = 6'h24;
	localparam logic [5:0] B_GAIN = 6'h2c;
	localparam int COEF_DEPTH = 48;
	typedef enum logic [2:0] {
		S_CMD = 3'b000,
		S_PIN = 3'b001,
		S_FILT = 3'b010,
		S_CWR = 3'b011,
		S_CRD = 3'b100,
		S_RPIN = 3'b101,
		S_RFILT = 3'b110
	} ccbd_state_type;
endpackage : ccbd_pkg

// ===== ccbd_sig_if.sv
// Configuration bundle from the decoder to the signaling byte formatter.
// Assumes both ends sit on mclk.
`timescale 1ns/100ps
interface ccbd_sig_if;
	logic [3:0] pin_dir;
	logic expansion;
	logic single;
	logic dev_addr;
	modport cfg (output pin_dir, output expansion, output single, output dev_addr);
	modport fmt (input pin_dir, input expansion, input single, input dev_addr);
endinterface : ccbd_sig_if

// ===== ccbd_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous pins and mclk is the destination clock.
`timescale 1ns/100ps
module ccbd_sync #(
	parameter int W = 4
) (
	input logic mclk,
	input logic reset,
	input logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				meta_reg[i] <= 1'b0;
				q[i] <= 1'b0;
			end else begin
				meta_reg[i] <= d[i];
				q[i] <= meta_reg[i];
			end
		end
	end
endmodule : ccbd_sync

// ===== ccbd_sigfmt.sv
// Signaling byte formatter: packs flag and pin inputs, unpacks received flags.
// Assumes synchronised inputs and a one-cycle receive byte strobe on mclk.
`timescale 1ns/100ps
module ccbd_sigfmt (
	input logic mclk,
	input logic reset,
	ccbd_sig_if.fmt cfg,
	input logic [2:0] flag_in,
	input logic [3:0] aux_in,
	input logic rx_sig_valid,
	input logic [7:0] rx_sig_byte,
	output logic [7:0] tx_sig_byte,
	output logic [7:0] tx_sig_oe,
	output logic [2:0] rx_flag_out,
	output logic [3:0] aux_pin_out,
	output logic [3:0] aux_pin_oe
);
	logic [3:0] dir_eff;
	logic [3:0] pin_tx;
	logic [3:0] single_oe;
	logic [3:0] single_rx;
	assign dir_eff = cfg.pin_dir | {3'h0, ~cfg.single};
	genvar i;
	for (i = 0; i < 4; i++) begin : g_pin
		assign pin_tx[i] = dir_eff[i] & aux_in[i];
		assign single_oe[i] = dir_eff[i] | ~cfg.expansion;
		assign single_rx[i] = dir_eff[i] ? aux_pin_out[i] : rx_sig_byte[i+1];
	end
	wire [7:0] tx_single = {flag_in, pin_tx, 1'b0};
	wire [7:0] oe_single = {3'h7, single_oe, ~cfg.expansion};
	wire [3:0] half = {flag_in, pin_tx[3]};
	wire [7:0] tx_shared = cfg.dev_addr ? {4'h0, half} : {half, 4'h0};
	wire [7:0] oe_shared = cfg.dev_addr ? 8'h0f : 8'hf0;
	wire [3:0] rx_half = cfg.dev_addr ? rx_sig_byte[3:0] : rx_sig_byte[7:4];
	wire rx_d = dir_eff[3] ? aux_pin_out[3] : rx_half[0];
	wire [3:0] rx_pins = cfg.single ? single_rx : {rx_d, aux_pin_out[2:0]};
	wire [2:0] rx_flags = cfg.single ? rx_sig_byte[7:5] : rx_half[3:1];
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tx_sig_byte <= 8'h00;
			tx_sig_oe <= 8'h00;
			aux_pin_oe <= 4'h0;
		end else begin
			tx_sig_byte <= cfg.single ? tx_single : tx_shared;
			tx_sig_oe <= cfg.single ? oe_single : oe_shared;
			aux_pin_oe <= ~dir_eff;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rx_flag_out <= 3'h0;
			aux_pin_out <= 4'h0;
		end else if (rx_sig_valid) begin
			rx_flag_out <= rx_flags;
			aux_pin_out <= rx_pins;
		end
	end
	a_pin_a_input: assert property (@(posedge mclk) disable iff (reset)
		!cfg.single |=> !aux_pin_oe[0]) else $error("pin A driven on shared port");
	a_pad_low: assert property (@(posedge mclk) disable iff (reset)
		(cfg.single && !cfg.expansion) |=> tx_sig_oe[0] && !tx_sig_byte[0])
		else $error("unused bit not driven low");
endmodule : ccbd_sigfmt

// ===== ccbd_top.sv
// Control byte interpreter, configuration registers, coefficient RAM and signaling.
// Assumes the line-card deserialiser hands over control and data bytes on mclk.
`timescale 1ns/100ps
module ccbd_top #(
	parameter logic DEV_ADDR = 1'b0,
	parameter int COEF_DEPTH = ccbd_pkg::COEF_DEPTH
) (
	input logic mclk,
	input logic reset,
	input logic ctrl_valid,
	input logic [7:0] ctrl_byte,
	output logic ctrl_ready,
	output logic resp_valid,
	output logic [7:0] resp_byte,
	input logic resp_ready,
	output logic power_state,
	output logic conference_sum,
	output logic balance_filter_off,
	output logic impedance_filter_on,
	output logic transmit_filter_on,
	output logic receive_filter_on,
	output logic gain_filter_on,
	output logic [2:0] test_select,
	output logic [4:0] test_active,
	output logic expansion_present,
	output logic addressing_choice,
	output logic mu_law_sel,
	output logic fixed_balance_coeffs,
	input logic [2:0] tx_flag_in,
	input logic [3:0] aux_pin_in,
	output logic [3:0] aux_pin_out,
	output logic [3:0] aux_pin_oe,
	output logic [2:0] rx_flag_out,
	input logic rx_sig_valid,
	input logic [7:0] rx_sig_byte,
	output logic [7:0] tx_sig_byte,
	output logic [7:0] tx_sig_oe
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (reset);

	ccbd_pkg::ccbd_state_type state_reg, state_next;
	logic [7:0] filt_reg, filt_next, pin_reg, pin_next;
	logic [7:0] coef_mem [COEF_DEPTH];
	logic [5:0] ptr_reg, ptr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic own_reg, own_next;
	logic pwr_reg, pwr_next, conf_reg, conf_next;
	logic ready_reg, valid_reg, valid_next;
	logic [7:0] byte_reg, byte_next;
	logic [4:0] test_reg;
	logic [2:0] flag_s;
	logic [3:0] aux_s;

	// Area base and byte count for a coefficient code; unknown codes carry no data
	function automatic logic [9:0] area_of(input logic [5:0] code);
		case (code)
			ccbd_pkg::C_BAL1: area_of = {ccbd_pkg::B_BAL1, ccbd_pkg::LEN_LONG};
			ccbd_pkg::C_BAL2: area_of = {ccbd_pkg::B_BAL2, ccbd_pkg::LEN_LONG};
			ccbd_pkg::C_BDLY: area_of = {ccbd_pkg::B_BDLY, ccbd_pkg::LEN_SHORT};
			ccbd_pkg::C_IMP: area_of = {ccbd_pkg::B_IMP, ccbd_pkg::LEN_LONG};
			ccbd_pkg::C_TXF: area_of = {ccbd_pkg::B_TXF, ccbd_pkg::LEN_LONG};
			ccbd_pkg::C_RXF: area_of = {ccbd_pkg::B_RXF, ccbd_pkg::LEN_LONG};
			ccbd_pkg::C_GAIN: area_of = {ccbd_pkg::B_GAIN, ccbd_pkg::LEN_SHORT};
			default: area_of = {6'h00, ccbd_pkg::LEN_NONE};
		endcase
	endfunction : area_of

	wire take = ctrl_valid & ready_reg;
	wire resp_take = valid_reg & resp_ready;
	wire own_cmd = ctrl_byte[ccbd_pkg::ADDR_BIT] == DEV_ADDR;
	wire is_idle = ctrl_byte[ccbd_pkg::OP_HI] & ctrl_byte[ccbd_pkg::OP_LO];
	wire is_status = ~ctrl_byte[ccbd_pkg::OP_HI] & ctrl_byte[ccbd_pkg::OP_LO];
	wire is_coef = ~ctrl_byte[ccbd_pkg::OP_LO];
	wire is_read = ctrl_byte[ccbd_pkg::RD_BIT];
	wire [1:0] len_code = ctrl_byte[ccbd_pkg::LEN_HI:0];
	wire [9:0] area = area_of(ctrl_byte[ccbd_pkg::CODE_HI:0]);
	wire [5:0] area_base = area[9:4];
	wire [3:0] area_len = area[3:0];
	wire last = cnt_reg == ccbd_pkg::CNT_LAST;
	wire [5:0] ptr_inc = ptr_reg + 6'h01;
	wire ready_next = state_next == ccbd_pkg::S_CMD || state_next == ccbd_pkg::S_PIN
		|| state_next == ccbd_pkg::S_FILT || state_next == ccbd_pkg::S_CWR;
	wire mem_wr = state_reg == ccbd_pkg::S_CWR && take && own_reg;
	wire [2:0] tsel = filt_reg[ccbd_pkg::TEST_HI:0];
	wire [4:0] test_dec = {tsel == ccbd_pkg::TEST_DLPCM, tsel == ccbd_pkg::TEST_DLBAL,
		tsel == ccbd_pkg::TEST_RXCUT, tsel == ccbd_pkg::TEST_HPOFF,
		tsel == ccbd_pkg::TEST_ALOOP};

	always_comb begin
		state_next = state_reg;
		filt_next = filt_reg;
		pin_next = pin_reg;
		ptr_next = ptr_reg;
		cnt_next = cnt_reg;
		own_next = own_reg;
		pwr_next = pwr_reg;
		conf_next = conf_reg;
		valid_next = valid_reg;
		byte_next = byte_reg;
		case (state_reg)
			ccbd_pkg::S_CMD: if (take && !is_idle) begin
				own_next = own_cmd;
				if (is_status) begin
					if (own_cmd) begin
						pwr_next = ctrl_byte[ccbd_pkg::PWR_BIT];
						conf_next = ctrl_byte[ccbd_pkg::CONF_BIT];
					end
					if (is_read) begin
						if (own_cmd && len_code == ccbd_pkg::LEN_TWO) begin
							valid_next = 1'b1;
							byte_next = pin_reg;
							state_next = ccbd_pkg::S_RPIN;
						end
					end else if (len_code == ccbd_pkg::LEN_ONE) begin
						state_next = ccbd_pkg::S_FILT;
					end else if (len_code == ccbd_pkg::LEN_TWO) begin
						state_next = ccbd_pkg::S_PIN;
					end
				end else if (is_coef && area_len != ccbd_pkg::LEN_NONE) begin
					ptr_next = area_base;
					cnt_next = area_len;
					if (!is_read) begin
						state_next = ccbd_pkg::S_CWR;
					end else if (own_cmd) begin
						valid_next = 1'b1;
						byte_next = coef_mem[area_base];
						state_next = ccbd_pkg::S_CRD;
					end
				end
			end
			ccbd_pkg::S_PIN: if (take) begin
				if (own_reg) begin
					pin_next = ctrl_byte;
				end
				state_next = ccbd_pkg::S_FILT;
			end
			ccbd_pkg::S_FILT: if (take) begin
				if (own_reg) begin
					filt_next = ctrl_byte;
				end
				state_next = ccbd_pkg::S_CMD;
			end
			ccbd_pkg::S_CWR: if (take) begin
				ptr_next = ptr_inc;
				cnt_next = cnt_reg - 4'h1;
				if (last) begin
					state_next = ccbd_pkg::S_CMD;
				end
			end
			ccbd_pkg::S_CRD: if (resp_take) begin
				if (last) begin
					byte_next = pin_reg;
					state_next = ccbd_pkg::S_RPIN;
				end else begin
					ptr_next = ptr_inc;
					cnt_next = cnt_reg - 4'h1;
					byte_next = coef_mem[ptr_inc];
				end
			end
			ccbd_pkg::S_RPIN: if (resp_take) begin
				byte_next = filt_reg;
				state_next = ccbd_pkg::S_RFILT;
			end
			ccbd_pkg::S_RFILT: if (resp_take) begin
				valid_next = 1'b0;
				state_next = ccbd_pkg::S_CMD;
			end
			default: state_next = ccbd_pkg::S_CMD;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= ccbd_pkg::S_CMD;
			filt_reg <= ccbd_pkg::FILT_RESET;
			pin_reg <= ccbd_pkg::PIN_RESET;
			ptr_reg <= 6'h00;
			cnt_reg <= 4'h0;
			own_reg <= 1'b0;
			pwr_reg <= 1'b0;
			conf_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			filt_reg <= filt_next;
			pin_reg <= pin_next;
			ptr_reg <= ptr_next;
			cnt_reg <= cnt_next;
			own_reg <= own_next;
			pwr_reg <= pwr_next;
			conf_reg <= conf_next;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ready_reg <= 1'b0;
			valid_reg <= 1'b0;
			byte_reg <= 8'h00;
			test_reg <= 5'h00;
		end else begin
			ready_reg <= ready_next;
			valid_reg <= valid_next;
			byte_reg <= byte_next;
			test_reg <= test_dec;
		end
	end

	// Coefficient RAM has no reset; reads before the first write are undefined
	always_ff @(posedge mclk) begin
		if (mem_wr) begin
			coef_mem[ptr_reg] <= ctrl_byte;
		end
	end

	assign ctrl_ready = ready_reg;
	assign resp_valid = valid_reg;
	assign resp_byte = byte_reg;
	assign power_state = pwr_reg;
	assign conference_sum = conf_reg;
	assign balance_filter_off = filt_reg[ccbd_pkg::BAL_OFF_BIT];
	assign impedance_filter_on = filt_reg[ccbd_pkg::IMP_ON_BIT];
	assign transmit_filter_on = filt_reg[ccbd_pkg::TXF_ON_BIT];
	assign receive_filter_on = filt_reg[ccbd_pkg::RXF_ON_BIT];
	assign gain_filter_on = filt_reg[ccbd_pkg::GAIN_ON_BIT];
	assign test_select = tsel;
	assign test_active = test_reg;
	assign expansion_present = pin_reg[ccbd_pkg::EXP_BIT];
	assign addressing_choice = pin_reg[ccbd_pkg::AM_BIT];
	assign mu_law_sel = pin_reg[ccbd_pkg::LAW_BIT];
	assign fixed_balance_coeffs = pin_reg[ccbd_pkg::FIXB_BIT];

	ccbd_sig_if sig_cfg ();
	assign sig_cfg.pin_dir = pin_reg[ccbd_pkg::DIR_HI:ccbd_pkg::DIR_LO];
	assign sig_cfg.expansion = pin_reg[ccbd_pkg::EXP_BIT];
	assign sig_cfg.single = pin_reg[ccbd_pkg::AM_BIT];
	assign sig_cfg.dev_addr = DEV_ADDR;

	ccbd_sync #(.W(7)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.d({tx_flag_in, aux_pin_in}),
		.q({flag_s, aux_s})
	);

	ccbd_sigfmt u_sigfmt (
		.mclk(mclk),
		.reset(reset),
		.cfg(sig_cfg),
		.flag_in(flag_s),
		.aux_in(aux_s),
		.rx_sig_valid(rx_sig_valid),
		.rx_sig_byte(rx_sig_byte),
		.tx_sig_byte(tx_sig_byte),
		.tx_sig_oe(tx_sig_oe),
		.rx_flag_out(rx_flag_out),
		.aux_pin_out(aux_pin_out),
		.aux_pin_oe(aux_pin_oe)
	);

	a_idle_no_change: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_idle)
		|=> state_reg == ccbd_pkg::S_CMD && $stable(filt_reg) && $stable(pin_reg) && !valid_reg)
		else $error("idle byte changed state");
	a_power_follow: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_status && own_cmd)
		|=> power_state == $past(ctrl_byte[ccbd_pkg::PWR_BIT]))
		else $error("power state not taken from status byte");
	a_len_two_path: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_status && !is_read
		&& len_code == ccbd_pkg::LEN_TWO) |=> state_reg == ccbd_pkg::S_PIN)
		else $error("two byte status write does not expect pin byte");
	a_pin_load: assert property (
		(state_reg == ccbd_pkg::S_PIN && take && own_reg)
		|=> pin_reg == $past(ctrl_byte) && state_reg == ccbd_pkg::S_FILT)
		else $error("pin register not loaded before filter byte");
	a_filt_load: assert property (
		(state_reg == ccbd_pkg::S_FILT && take && own_reg)
		|=> filt_reg == $past(ctrl_byte) && state_reg == ccbd_pkg::S_CMD)
		else $error("filter register not loaded");
	a_reset_vals: assert property (
		$past(reset) |-> filt_reg == 8'h00 && pin_reg == 8'hff)
		else $error("reset values wrong");
	a_sread_order: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_status && is_read && own_cmd
		&& len_code == 2'h2) |=> resp_valid && resp_byte == pin_reg)
		else $error("status read does not start with pin register");
	a_coef_tail: assert property (
		(state_reg == ccbd_pkg::S_CRD && resp_take && last)
		|=> state_reg == ccbd_pkg::S_RPIN && resp_byte == pin_reg)
		else $error("readback tail missing pin register");
	a_coef_count: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_coef && !is_read && area_len != 4'h0)
		|=> state_reg == ccbd_pkg::S_CWR && cnt_reg == $past(area_len) && ctrl_ready)
		else $error("coefficient write count wrong");
	a_test_decode: assert property (
		(tsel == ccbd_pkg::TEST_DLBAL) |=> test_active == 5'h08)
		else $error("balance loopback test not decoded");
	a_coef_read: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && is_coef && is_read && own_cmd
		&& area_len != ccbd_pkg::LEN_NONE)
		|=> state_reg == ccbd_pkg::S_CRD && resp_valid && !ctrl_ready)
		else $error("coefficient readback not started");
	a_rfilt_tail: assert property (
		(state_reg == ccbd_pkg::S_RPIN && resp_take)
		|=> state_reg == ccbd_pkg::S_RFILT && resp_valid && resp_byte == filt_reg)
		else $error("filter register not returned after pin register");
	a_other_quiet: assert property (
		(state_reg == ccbd_pkg::S_CMD && take && !is_idle && is_read && !own_cmd)
		|=> !resp_valid && ctrl_ready)
		else $error("read for the other codec answered");
endmodule : ccbd_top

// ===== ccbd_ctrl_model.sv
// Line controller model: offers control and data bytes, consumes readback bytes.
// Assumes byte-level valid/ready handshake on mclk; tasks are called at a clock edge.
`timescale 1ns/100ps
module ccbd_ctrl_model (
	input wire logic mclk,
	input wire logic ctrl_ready,
	output logic ctrl_valid = 1'b0,
	output logic [7:0] ctrl_byte = 8'h00,
	input wire logic resp_valid,
	input wire logic [7:0] resp_byte,
	output logic resp_ready = 1'b0
);
	logic [7:0] got_q[$];
	bit slow = 1'b0;
	// Bytes that were never taken, so the bench can fail them
	int lost = 0;
	// Byte held until an edge samples ready high
	task automatic send(input logic [7:0] b);
		int tmo;
		tmo = 0;
		ctrl_valid <= 1'b1;
		ctrl_byte <= b;
		do begin
			@(posedge mclk);
			tmo++;
		end while (ctrl_ready !== 1'b1 && tmo < 50);
		if (ctrl_ready !== 1'b1)
			lost++;
	endtask : send
	// Released byte lines do not keep the last value
	task automatic release_bus();
		ctrl_valid <= 1'b0;
		ctrl_byte <= ~ctrl_byte;
		@(posedge mclk);
	endtask : release_bus
	// Slow mode stalls every other cycle
	always @(posedge mclk) begin
		if (resp_valid === 1'b1 && resp_ready === 1'b1)
			got_q.push_back(resp_byte);
		resp_ready <= slow ? ~resp_ready : 1'b1;
	end
endmodule : ccbd_ctrl_model

// ===== test_codec_control_byte_decoder.sv
// Self-checking bench for the codec control byte decoder.
// Assumes ccbd_top with DEV_ADDR 0 and the controller model beside it.
`timescale 1ns/100ps
module test_codec_control_byte_decoder;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic rx_sig_valid = 1'b0;
	logic [7:0] rx_sig_byte = 8'h00;
	logic [2:0] tx_flag_in = 3'h0;
	logic [3:0] aux_pin_in = 4'h0;
	logic ctrl_valid, ctrl_ready, resp_valid, resp_ready, power_state, conference_sum;
	logic balance_filter_off, impedance_filter_on, transmit_filter_on, receive_filter_on;
	logic gain_filter_on, expansion_present, addressing_choice, mu_law_sel, fixed_balance_coeffs;
	logic [7:0] ctrl_byte, resp_byte, tx_sig_byte, tx_sig_oe;
	logic [2:0] test_select, rx_flag_out;
	logic [4:0] test_active;
	logic [3:0] aux_pin_out, aux_pin_oe;
	int n_fail = 0;
	int num_checks = 0;
	logic [7:0] pin_e = 8'hff;
	logic [7:0] filt_e = 8'h00;
	wire [7:0] filt_v = {balance_filter_off, impedance_filter_on, transmit_filter_on,
		receive_filter_on, gain_filter_on, test_select};
	// Pin directions seen through the enables, valid while one codec owns the port
	wire [7:0] pin_v = {~aux_pin_oe, expansion_present, addressing_choice, mu_law_sel,
		fixed_balance_coeffs};
	always #25 mclk = ~mclk;
	ccbd_top dut_u (.mclk(mclk), .reset(reset), .ctrl_valid(ctrl_valid), .ctrl_byte(ctrl_byte),
		.ctrl_ready(ctrl_ready), .resp_valid(resp_valid), .resp_byte(resp_byte),
		.resp_ready(resp_ready), .power_state(power_state), .conference_sum(conference_sum),
		.balance_filter_off(balance_filter_off), .impedance_filter_on(impedance_filter_on),
		.transmit_filter_on(transmit_filter_on), .receive_filter_on(receive_filter_on),
		.gain_filter_on(gain_filter_on), .test_select(test_select), .test_active(test_active),
		.expansion_present(expansion_present), .addressing_choice(addressing_choice),
		.mu_law_sel(mu_law_sel), .fixed_balance_coeffs(fixed_balance_coeffs),
		.tx_flag_in(tx_flag_in), .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out),
		.aux_pin_oe(aux_pin_oe), .rx_flag_out(rx_flag_out), .rx_sig_valid(rx_sig_valid),
		.rx_sig_byte(rx_sig_byte), .tx_sig_byte(tx_sig_byte), .tx_sig_oe(tx_sig_oe));
	ccbd_ctrl_model ctl_u (.mclk(mclk), .ctrl_ready(ctrl_ready), .ctrl_valid(ctrl_valid),
		.ctrl_byte(ctrl_byte), .resp_valid(resp_valid), .resp_byte(resp_byte),
		.resp_ready(resp_ready));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] b[$]);
		foreach (b[i]) ctl_u.send(b[i]);
		ctl_u.release_bus();
		repeat (2) @(posedge mclk);
		chk(8'(ctl_u.lost), 8'h00);
	endtask : cmd
	task automatic cfg(input logic [1:0] pc);
		chk(pin_v, pin_e);
		chk(filt_v, filt_e);
		chk({6'h00, power_state, conference_sum}, {6'h00, pc});
	endtask : cfg
	task automatic wait_resp(input int n);
		for (int k = 0; k < 100 && ctl_u.got_q.size() < n; k++) @(posedge mclk);
		repeat (4) @(posedge mclk);
		chk(8'(ctl_u.got_q.size()), 8'(n));
	endtask : wait_resp
	task automatic rx(input logic [7:0] b);
		rx_sig_valid <= 1'b1;
		rx_sig_byte <= b;
		@(posedge mclk);
		rx_sig_valid <= 1'b0;
		rx_sig_byte <= ~b;
		repeat (2) @(posedge mclk);
	endtask : rx
	task automatic t_reset();
		cfg(2'b00);
		chk(tx_sig_oe, 8'hfe);
	endtask : t_reset
	task automatic t_status_wr();
		// Address bit kept zero: one codec on the port
		cmd('{8'h26, 8'hf4, 8'h80});
		pin_e = 8'hf4;
		filt_e = 8'h80;
		cfg(2'b10);
		cmd('{8'h37, 8'h7b});
		filt_e = 8'h7b;
		cfg(2'b11);
		cmd('{8'h24, 8'h0c, 8'hff});
		cfg(2'b10);
	endtask : t_status_wr
	task automatic t_tests();
		logic [4:0] act[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h08, 5'h10};
		for (int i = 0; i < 8; i++) begin
			filt_e = {5'h0f, 3'(i)};
			cmd('{8'h27, filt_e});
			chk(filt_v, filt_e);
			chk({3'h0, test_active}, {3'h0, act[i]});
		end
	endtask : t_tests
	task automatic t_coef();
		ctl_u.slow = 1'b1;
		ctl_u.got_q.delete();
		cmd('{8'h18, 8'h19, 8'h19, 8'h11, 8'h19});
		cmd('{8'h98, 8'h26, 8'h26, 8'h26, 8'h26});
		cfg(2'b10);
		cmd('{8'h58});
		wait_resp(6);
		foreach (ctl_u.got_q[i])
			chk(ctl_u.got_q[i], i < 4 ? (i == 2 ? 8'h11 : 8'h19) : (i == 4 ? pin_e : filt_e));
		ctl_u.got_q.delete();
		cmd('{8'h30, 8'h41, 8'hb0, 8'h20, 8'h92});
		cmd('{8'h70});
		wait_resp(6);
		chk(ctl_u.got_q[0], 8'h41);
		chk(ctl_u.got_q[3], 8'h92);
		chk(ctl_u.got_q[5], filt_e);
	endtask : t_coef
	task automatic t_status_rd();
		ctl_u.got_q.delete();
		cmd('{8'he6, 8'h66});
		wait_resp(2);
		chk(ctl_u.got_q[0], pin_e);
		chk(ctl_u.got_q[1], filt_e);
		ctl_u.slow = 1'b0;
	endtask : t_status_rd
	task automatic t_sig();
		tx_flag_in <= 3'h5;
		aux_pin_in <= 4'ha;
		repeat (5) @(posedge mclk);
		chk(tx_sig_byte, 8'hb4);
		chk(tx_sig_oe, 8'hff);
		cmd('{8'h26, 8'hfc, filt_e});
		chk(tx_sig_oe, 8'hfe);
		cmd('{8'h26, 8'h0c, filt_e});
		chk(tx_sig_byte, 8'ha0);
		chk(tx_sig_oe, 8'he0);
		rx(8'h5b);
		chk({1'b0, rx_flag_out, aux_pin_out}, 8'h2d);
		chk({4'h0, aux_pin_oe}, 8'h0f);
		cmd('{8'h26, 8'h04, filt_e});
		chk(tx_sig_oe, 8'hff);
		// Shared port without expansion logic
		cmd('{8'h26, 8'h00, filt_e});
		chk(tx_sig_oe, 8'hf0);
		chk({4'h0, tx_sig_byte[7:4]}, 8'h0a);
		chk({7'h00, aux_pin_oe[0]}, 8'h00);
		rx(8'h3c);
		chk({4'h0, rx_flag_out, aux_pin_out[3]}, 8'h03);
	endtask : t_sig
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		t_reset();
		t_status_wr();
		t_tests();
		t_coef();
		t_status_rd();
		t_sig();
		end_of_test();
	end
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end
endmodule : test_codec_control_byte_decoder
